// ### bench/stfs_host_model.sv
`timescale 1ns/1ps
module stfs_host_model (
  input  wire logic aclk,
  output logic      pa,
  output logic      pa_n,
  output logic      sb,
  output logic      sb_n
);
  // One line state of both complementary pairs, held three clocks
  task automatic put(input logic a, input logic b);
    pa   <= a;
    pa_n <= ~a;
    sb   <= b;
    sb_n <= ~b;
    repeat (3) @(posedge aclk);
  endtask

  // Lines idle with both pairs off at time zero
  initial begin
    {pa, sb} = 2'b00;
    {pa_n, sb_n} = 2'b11;
  end
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
`include "stfs_consts.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  mismatches++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
  import stfs_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        ref_pulse_a, ref_pulse_a_n, ref_sign_b, ref_sign_b_n;
  logic        prop_ctrl_in, fwd_current_limit_in, rev_current_limit_in;
  logic [15:0] analog_in_1, analog_in_2, torque_fb, motor_speed;
  logic [15:0] pulse_speed, pos_error, speed_ref_out, torque_ref_out;
  logic [15:0] torque_limit_out, torque_ff_out, speed_limit_out;
  logic [15:0] monitor_out_1, monitor_out_2;
  logic        speed_ref_valid, torque_ref_valid, torque_limit_valid;
  logic        torque_ff_valid, speed_limit_valid, step_fwd, step_rev;
  logic        p_control_en, zero_clamp_cmd, pulse_inhibit, fwd_tlim_en;
  logic        rev_tlim_en;
  logic [4:0]  vld;
  stfs_loop_t  active_loop;
  int          mismatches, n_compared, cycles, nf, nr;

  // Reference-valid flags gathered for table compares
  assign vld = {speed_ref_valid, torque_ref_valid, torque_limit_valid,
                torque_ff_valid, speed_limit_valid};

  stfs_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ref_pulse_a, .ref_pulse_a_n, .ref_sign_b,
    .ref_sign_b_n, .prop_ctrl_in, .fwd_current_limit_in,
    .rev_current_limit_in, .analog_in_1, .analog_in_2, .torque_fb,
    .motor_speed, .pulse_speed, .pos_error, .speed_ref_out, .speed_ref_valid,
    .torque_ref_out, .torque_ref_valid, .torque_limit_out,
    .torque_limit_valid, .torque_ff_out, .torque_ff_valid, .speed_limit_out,
    .speed_limit_valid, .step_fwd, .step_rev, .p_control_en, .zero_clamp_cmd,
    .pulse_inhibit, .fwd_tlim_en, .rev_tlim_en, .active_loop, .monitor_out_1,
    .monitor_out_2);

  stfs_host_model u_host (.aclk, .pa(ref_pulse_a), .pa_n(ref_pulse_a_n),
    .sb(ref_sign_b), .sb_n(ref_sign_b_n));

  // 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Step pulse counters and hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (step_fwd === 1'b1) nf <= nf + 1;
    if (step_rev === 1'b1) nr <= nr + 1;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Write with address and data offered together; waits bounded
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    // Each channel released at the edge its own ready is seen high
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    `CHK("write resp", `STFS_RESP_OKAY, s_axi_bresp)
    s_axi_bready <= 1'b0;
    if (n >= 50) mismatches++;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    // Read data taken at the edge where rvalid is seen high
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    if (n >= 50) mismatches++;
  endtask

  task automatic settle();
    repeat (4) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic cfg(input logic [3:0] m, input logic [15:0] s2);
    wr(`STFS_OFS_METHOD, {28'h0, m});
    wr(`STFS_OFS_SW2, {16'h0, s2});
    settle();
  endtask

  task automatic contact(input logic [3:0] m, input logic p);
    cfg(m, 16'h0);
    @(posedge aclk);
    {prop_ctrl_in, fwd_current_limit_in, rev_current_limit_in} <= {p, p, ~p};
    settle();
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rd(`STFS_OFS_SW2, d, r);
    `CHK("sw2 reset", {16'h0, `STFS_RST_SW}, d)
    rd(`STFS_OFS_METHOD, d, r);
    `CHK("method reset", {28'h0, `STFS_RST_METHOD}, d)
    wr(`STFS_OFS_SW1, 32'h0000a5c3);
    rd(`STFS_OFS_SW1, d, r);
    `CHK("sw1 value", 32'h0000a5c3, d)
    rd(8'h40, d, r);
    `CHK("unmapped resp", `STFS_RESP_SLVERR, r)
    `CHK("unmapped data", 32'h0, d)
  endtask

  task automatic t_analog();
    logic [3:0]  m [5];
    logic [15:0] s [5];
    logic [4:0]  v [5];
    m = '{`STFS_M_SPEED, `STFS_M_SPEED, `STFS_M_SPEED, `STFS_M_TORQUE,
          `STFS_M_TORQUE};
    s = '{16'h0, 16'h1 << `STFS_B_TLIM, 16'h1 << `STFS_B_TFF, 16'h0,
          16'h1 << `STFS_B_SPD_LIM};
    v = '{5'b10000, 5'b10100, 5'b10010, 5'b01000, 5'b01001};
    for (int i = 0; i < 5; i++) begin
      @(posedge aclk);
      {analog_in_1, analog_in_2} <= {16'h1230 + 16'(i), 16'h5670 - 16'(i)};
      cfg(m[i], s[i]);
      `CHK("ref valids", v[i], vld)
      if (v[i][4]) `CHK("speed ref", analog_in_1, speed_ref_out)
      if (v[i][3]) `CHK("torque ref", analog_in_2, torque_ref_out)
      if (v[i][2]) `CHK("torque lim", analog_in_2, torque_limit_out)
      if (v[i][1]) `CHK("torque ff", analog_in_2, torque_ff_out)
      if (v[i][0]) `CHK("speed lim", analog_in_1, speed_limit_out)
    end
  endtask

  task automatic t_monitor();
    cfg(`STFS_M_SPEED, 16'h0);
    `CHK("mon1 torque", torque_fb, monitor_out_1)
    `CHK("mon2 speed", motor_speed, monitor_out_2)
    cfg(`STFS_M_SPEED, 16'h00c0);
    `CHK("mon1 speed ref", analog_in_1, monitor_out_1)
    cfg(`STFS_M_POS, 16'h00c0);
    `CHK("mon1 pulse speed", pulse_speed, monitor_out_1)
    `CHK("mon2 pos error", pos_error, monitor_out_2)
  endtask

  // Plays eight line states (a, b pairs, first pair in the top bits)
  task automatic steps(input logic [3:0] m, input logic [2:0] f,
                       input logic [15:0] q, input int ef, input int er);
    cfg(m, {10'h0, f, 3'h0});
    nf = 0;
    nr = 0;
    @(posedge aclk);
    for (int i = 7; i >= 0; i--) u_host.put(q[2*i+1], q[2*i]);
    settle();
    `CHK("fwd steps", ef, nf)
    `CHK("rev steps", er, nr)
  endtask

  task automatic t_pulses();
    steps(`STFS_M_POS, `STFS_FMT_SIGN, 16'h2200, 2, 0);
    steps(`STFS_M_POS, `STFS_FMT_SIGN, 16'h7740, 0, 2);
    steps(`STFS_M_POS, `STFS_FMT_CWCCW, 16'h8480, 2, 1);
    steps(`STFS_M_POS, `STFS_FMT_QX1, 16'hb4b4, 2, 0);
    steps(`STFS_M_POS, `STFS_FMT_QX1, 16'h7878, 0, 2);
    steps(`STFS_M_POS, `STFS_FMT_QX2, 16'hb4b4, 4, 0);
    steps(`STFS_M_POS, `STFS_FMT_QX4, 16'h7878, 0, 8);
    contact(`STFS_M_INHIBIT, 1'b1);
    steps(`STFS_M_INHIBIT, `STFS_FMT_SIGN, 16'h2200, 0, 0);
  endtask

  task automatic t_contacts();
    logic [3:0] m [5];
    stfs_loop_t lo [3];
    stfs_loop_t hi [3];
    m = '{`STFS_M_SPEED, `STFS_M_POS, `STFS_M_TORQUE, `STFS_M_ZCLAMP,
          `STFS_M_INHIBIT};
    lo = '{STFS_L_POS, STFS_L_POS, STFS_L_TRQ};
    hi = '{STFS_L_SPD, STFS_L_TRQ, STFS_L_SPD};
    for (int i = 0; i < 10; i++) begin
      contact(m[i/2], i[0]);
      `CHK("p control", i[0] && i < 4, p_control_en)
      `CHK("zero clamp", i[0] && i / 2 == 3, zero_clamp_cmd)
      `CHK("inhibit", i[0] && i / 2 == 4, pulse_inhibit)
      `CHK("fwd limit", i[0], fwd_tlim_en)
      `CHK("rev limit", ~i[0], rev_tlim_en)
    end
    for (int i = 0; i < 6; i++) begin
      contact(4'(`STFS_M_POS_SPD + i / 2), i[0]);
      `CHK("mode switch", i[0] ? hi[i/2] : lo[i/2], active_loop)
    end
  endtask

  task automatic t_run();
    logic [31:0] d;
    logic [1:0]  r;
    cfg(`STFS_M_SPEED, 16'h1 << `STFS_B_TLIM);
    wr(`STFS_OFS_CTRL, 32'h1);
    wr(`STFS_OFS_SW2, 32'h1 << `STFS_B_TFF);
    settle();
    `CHK("frozen", 5'b10100, vld)
    rd(`STFS_OFS_STATUS, d, r);
    `CHK("status run", 1'b1, d[0])
    `CHK("status word", {`STFS_M_SPEED, 8'h19}, d[11:0])
    wr(`STFS_OFS_CTRL, 32'h0);
    settle();
    `CHK("released", 5'b10010, vld)
  endtask

  // Reset, then the scenarios in turn
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb} = '0;
    {prop_ctrl_in, fwd_current_limit_in, rev_current_limit_in} = 3'b000;
    {analog_in_1, analog_in_2, torque_fb} = {16'h1234, 16'h5678, 16'h9abc};
    {motor_speed, pulse_speed, pos_error} = {16'hdef0, 16'h0f1e, 16'h2d3c};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_analog();
    t_monitor();
    t_pulses();
    t_contacts();
    t_run();
    close_out();
  end
endmodule

// ### verilog/stfs_consts.svh
// Behaviour
// - Speed loop, bit 8 set, bit 9 clear: input 2 limits torque.
// - Torque loop: input 2 is torque reference; input 1 speed limit if bit 2.
// - Pulse format 000: pulse pair gives steps, sign pair gives direction.
// - Pulse format 001: pulse pair steps forward, sign pair steps reverse.
// - Quadrature A/B decode, codes 010 x1, 011 x2, one more code x4.
// - Monitor 1: torque if bit 6 clear, else speed or pulse speed reference, zero in torque loop.
// - Monitor 2: motor speed if bit 7 clear, else position error in position loop, zero otherwise.
// - Methods 0,1: prop input gives P control; method 2 ignores it; limits always.
// - Methods 7, 8, 9: prop input switches between the two combined modes.
// - Method 10: prop input commands zero clamp.
// - Method 11: prop input inhibits reference pulse acceptance.
// - Switch word bits are on/off function selects, except bits 5 to 3, the 3-bit pulse format code.
`ifndef STFS_CONSTS_SVH
`define STFS_CONSTS_SVH

// Register byte offsets
`define STFS_OFS_SW1     8'h00
`define STFS_OFS_SW2     8'h04
`define STFS_OFS_METHOD  8'h08
`define STFS_OFS_CTRL    8'h0c
`define STFS_OFS_STATUS  8'h10

// Reset values
`define STFS_RST_SW      16'h0000
`define STFS_RST_METHOD  4'h0

// Switch word 2 bit positions, and the run bit of the control register
`define STFS_B_SPD_LIM   2
`define STFS_B_FMT_LO    3
`define STFS_B_FMT_HI    5
`define STFS_B_MON1      6
`define STFS_B_MON2      7
`define STFS_B_TLIM      8
`define STFS_B_TFF       9
`define STFS_B_RUN       0

// Pulse formats (bits 5, 4, 3)
`define STFS_FMT_SIGN    3'h0
`define STFS_FMT_CWCCW   3'h1
`define STFS_FMT_QX1     3'h2
`define STFS_FMT_QX2     3'h3
`define STFS_FMT_QX4     3'h4

// Control methods
`define STFS_M_SPEED     4'h0
`define STFS_M_POS       4'h1
`define STFS_M_TORQUE    4'h2
`define STFS_M_POS_SPD   4'h7
`define STFS_M_POS_TRQ   4'h8
`define STFS_M_TRQ_SPD   4'h9
`define STFS_M_ZCLAMP    4'ha
`define STFS_M_INHIBIT   4'hb

// Bus responses
`define STFS_RESP_OKAY   2'h0
`define STFS_RESP_SLVERR 2'h2

`endif

// ### verilog/stfs_pkg.sv
package stfs_pkg;
  // Bus channel handshake states, Gray along the path
  typedef enum logic [1:0] {
    STFS_IDLE = 2'b00,
    STFS_TAKE = 2'b01,
    STFS_RESP = 2'b11
  } stfs_bus_st_t;

  // Loop that is currently in effect
  typedef enum logic [1:0] {
    STFS_L_SPD = 2'b00,
    STFS_L_POS = 2'b01,
    STFS_L_TRQ = 2'b11
  } stfs_loop_t;
endpackage

// ### verilog/stfs_top.sv
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "stfs_consts.svh"
module stfs_top (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               ref_pulse_a,
  input  wire logic               ref_pulse_a_n,
  input  wire logic               ref_sign_b,
  input  wire logic               ref_sign_b_n,
  input  wire logic               prop_ctrl_in,
  input  wire logic               fwd_current_limit_in,
  input  wire logic               rev_current_limit_in,
  input  wire logic [15:0]        analog_in_1,
  input  wire logic [15:0]        analog_in_2,
  input  wire logic [15:0]        torque_fb,
  input  wire logic [15:0]        motor_speed,
  input  wire logic [15:0]        pulse_speed,
  input  wire logic [15:0]        pos_error,
  output logic [15:0]             speed_ref_out,
  output logic                    speed_ref_valid,
  output logic [15:0]             torque_ref_out,
  output logic                    torque_ref_valid,
  output logic [15:0]             torque_limit_out,
  output logic                    torque_limit_valid,
  output logic [15:0]             torque_ff_out,
  output logic                    torque_ff_valid,
  output logic [15:0]             speed_limit_out,
  output logic                    speed_limit_valid,
  output logic                    step_fwd,
  output logic                    step_rev,
  output logic                    p_control_en,
  output logic                    zero_clamp_cmd,
  output logic                    pulse_inhibit,
  output logic                    fwd_tlim_en,
  output logic                    rev_tlim_en,
  output stfs_pkg::stfs_loop_t    active_loop,
  output logic [15:0]             monitor_out_1,
  output logic [15:0]             monitor_out_2
);
  import stfs_pkg::*;

  stfs_bus_st_t wr_st;
  stfs_bus_st_t rd_st;
  logic [15:0]  function_switch_word_1;
  logic [15:0]  function_switch_word_2;
  logic [3:0]   control_method_setting;
  logic         run;
  logic [15:0]  act_sw1;
  logic [15:0]  act_sw2;
  logic [3:0]   act_method;
  logic [7:0]   wr_addr;
  logic [31:0]  wr_data;
  logic [3:0]   wr_strb;
  logic [31:0]  next_rdata;
  logic         next_rerr;
  logic [31:0]  wmask;
  stfs_loop_t   next_loop;
  logic [2:0]   fmt;
  logic         a_now;
  logic         b_now;
  logic         a_prev;
  logic         b_prev;
  logic         a_rise;
  logic         a_fall;
  logic         b_rise;
  logic         b_fall;
  logic         next_fwd;
  logic         next_rev;
  logic         next_inh;

  // Byte lane mask from write strobes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{wr_strb[gi]}};
    end
  endgenerate

  // Write channel: address and data taken together, then response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st         <= STFS_IDLE;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `STFS_RESP_OKAY;
      wr_addr       <= 8'h00;
      wr_data       <= 32'h0000_0000;
      wr_strb       <= 4'h0;
    end else begin
      case (wr_st)
        STFS_IDLE: begin
          if (s_axi_awvalid && s_axi_wvalid) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            wr_st         <= STFS_TAKE;
          end
        end
        STFS_TAKE: begin
          s_axi_awready <= 1'b0;
          s_axi_wready  <= 1'b0;
          wr_addr       <= s_axi_awaddr;
          wr_data       <= s_axi_wdata;
          wr_strb       <= s_axi_wstrb;
          s_axi_bvalid  <= 1'b1;
          s_axi_bresp   <= (s_axi_awaddr > `STFS_OFS_STATUS ||
                            s_axi_awaddr[1:0] != 2'h0) ?
                           `STFS_RESP_SLVERR : `STFS_RESP_OKAY;
          wr_st         <= STFS_RESP;
        end
        STFS_RESP: begin
          wr_strb <= 4'h0;
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_st        <= STFS_IDLE;
          end
        end
        default: wr_st <= STFS_IDLE;
      endcase
    end
  end

  // Stored settings: switch words, method code and run bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      function_switch_word_1 <= `STFS_RST_SW;
      function_switch_word_2 <= `STFS_RST_SW;
      control_method_setting <= `STFS_RST_METHOD;
      run                    <= 1'b0;
    end else if (wr_st == STFS_RESP && wr_strb != 4'h0) begin
      case (wr_addr)
        `STFS_OFS_SW1: function_switch_word_1 <=
          (function_switch_word_1 & ~wmask[15:0]) |
          (wr_data[15:0] & wmask[15:0]);
        `STFS_OFS_SW2: function_switch_word_2 <=
          (function_switch_word_2 & ~wmask[15:0]) |
          (wr_data[15:0] & wmask[15:0]);
        `STFS_OFS_METHOD: begin
          if (wr_strb[0]) begin
            control_method_setting <= wr_data[3:0];
          end
        end
        `STFS_OFS_CTRL: begin
          if (wr_strb[0]) begin
            run <= wr_data[`STFS_B_RUN];
          end
        end
        default: run <= run;
      endcase
    end
  end

  // Active copy follows stored settings only while stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_sw1    <= `STFS_RST_SW;
      act_sw2    <= `STFS_RST_SW;
      act_method <= `STFS_RST_METHOD;
    end else if (!run) begin
      act_sw1    <= function_switch_word_1;
      act_sw2    <= function_switch_word_2;
      act_method <= control_method_setting;
    end
  end

  // Read data decode
  always_comb begin
    next_rerr  = 1'b0;
    next_rdata = 32'h0000_0000;
    case (s_axi_araddr)
      `STFS_OFS_SW1:    next_rdata[15:0] = function_switch_word_1;
      `STFS_OFS_SW2:    next_rdata[15:0] = function_switch_word_2;
      `STFS_OFS_METHOD: next_rdata[3:0]  = control_method_setting;
      `STFS_OFS_CTRL:   next_rdata[0]    = run;
      `STFS_OFS_STATUS: next_rdata[11:0] = {act_method, 1'b0,
                                            pulse_inhibit,
                                            zero_clamp_cmd, p_control_en,
                                            fmt <= `STFS_FMT_QX4,
                                            active_loop, run};
      default:          next_rerr        = 1'b1;
    endcase
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st         <= STFS_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `STFS_RESP_OKAY;
    end else begin
      case (rd_st)
        STFS_IDLE: begin
          if (s_axi_arvalid) begin
            s_axi_arready <= 1'b1;
            rd_st         <= STFS_TAKE;
          end
        end
        STFS_TAKE: begin
          s_axi_arready <= 1'b0;
          s_axi_rvalid  <= 1'b1;
          s_axi_rdata   <= next_rdata;
          s_axi_rresp   <= next_rerr ? `STFS_RESP_SLVERR : `STFS_RESP_OKAY;
          rd_st         <= STFS_RESP;
        end
        STFS_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_st        <= STFS_IDLE;
          end
        end
        default: rd_st <= STFS_IDLE;
      endcase
    end
  end

  // Loop in effect from method and prop input
  always_comb begin
    case (act_method)
      `STFS_M_POS, `STFS_M_INHIBIT: next_loop = STFS_L_POS;
      `STFS_M_TORQUE:               next_loop = STFS_L_TRQ;
      `STFS_M_POS_SPD: next_loop = prop_ctrl_in ? STFS_L_SPD
                                                : STFS_L_POS;
      `STFS_M_POS_TRQ: next_loop = prop_ctrl_in ? STFS_L_TRQ
                                                : STFS_L_POS;
      `STFS_M_TRQ_SPD: next_loop = prop_ctrl_in ? STFS_L_SPD
                                                : STFS_L_TRQ;
      default:                      next_loop = STFS_L_SPD;
    endcase
  end

  // Contact input meanings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_loop    <= STFS_L_SPD;
      p_control_en   <= 1'b0;
      zero_clamp_cmd <= 1'b0;
      pulse_inhibit  <= 1'b0;
      fwd_tlim_en    <= 1'b0;
      rev_tlim_en    <= 1'b0;
    end else begin
      active_loop    <= next_loop;
      p_control_en   <= prop_ctrl_in && (act_method == `STFS_M_SPEED ||
                        act_method == `STFS_M_POS);
      zero_clamp_cmd <= prop_ctrl_in &&
                        act_method == `STFS_M_ZCLAMP;
      pulse_inhibit  <= next_inh;
      fwd_tlim_en    <= fwd_current_limit_in;
      rev_tlim_en    <= rev_current_limit_in;
    end
  end

  // Analog reference roles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_ref_out      <= 16'h0000;
      speed_ref_valid    <= 1'b0;
      torque_ref_out     <= 16'h0000;
      torque_ref_valid   <= 1'b0;
      torque_limit_out   <= 16'h0000;
      torque_limit_valid <= 1'b0;
      torque_ff_out      <= 16'h0000;
      torque_ff_valid    <= 1'b0;
      speed_limit_out    <= 16'h0000;
      speed_limit_valid  <= 1'b0;
    end else begin
      speed_ref_out      <= analog_in_1;
      speed_ref_valid    <= next_loop == STFS_L_SPD;
      torque_ref_out     <= analog_in_2;
      torque_ref_valid   <= next_loop == STFS_L_TRQ;
      torque_limit_out   <= analog_in_2;
      torque_limit_valid <= next_loop == STFS_L_SPD &&
                            act_sw2[`STFS_B_TLIM] && !act_sw2[`STFS_B_TFF];
      torque_ff_out      <= analog_in_2;
      torque_ff_valid    <= next_loop == STFS_L_SPD &&
                            !act_sw2[`STFS_B_TLIM] && act_sw2[`STFS_B_TFF];
      speed_limit_out    <= analog_in_1;
      speed_limit_valid  <= next_loop == STFS_L_TRQ &&
                            act_sw2[`STFS_B_SPD_LIM];
    end
  end

  // Pulse pair levels and edges
  assign fmt    = act_sw2[`STFS_B_FMT_HI:`STFS_B_FMT_LO];
  assign a_now  = ref_pulse_a && !ref_pulse_a_n;
  assign b_now  = ref_sign_b && !ref_sign_b_n;
  assign a_rise = a_now && !a_prev;
  assign a_fall = !a_now && a_prev;
  assign b_rise = b_now && !b_prev;
  assign b_fall = !b_now && b_prev;
  assign next_inh = prop_ctrl_in && act_method == `STFS_M_INHIBIT;

  // Step decode per pulse format
  always_comb begin
    next_fwd = 1'b0;
    next_rev = 1'b0;
    case (fmt)
      `STFS_FMT_SIGN: begin
        next_fwd = a_rise && !b_now;
        next_rev = a_rise && b_now;
      end
      `STFS_FMT_CWCCW: begin
        next_fwd = a_rise;
        next_rev = b_rise;
      end
      `STFS_FMT_QX1: begin
        next_fwd = a_rise && !b_now;
        next_rev = a_rise && b_now;
      end
      `STFS_FMT_QX2: begin
        next_fwd = (a_rise && !b_now) || (a_fall && b_now);
        next_rev = (a_rise && b_now) || (a_fall && !b_now);
      end
      `STFS_FMT_QX4: begin
        next_fwd = (a_rise && !b_now) || (a_fall && b_now) ||
                   (b_rise && a_now) || (b_fall && !a_now);
        next_rev = (a_rise && b_now) || (a_fall && !b_now) ||
                   (b_rise && !a_now) || (b_fall && a_now);
      end
      default: begin
        next_fwd = 1'b0;
        next_rev = 1'b0;
      end
    endcase
  end

  // Step outputs, gated by the pulse inhibit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_prev   <= 1'b0;
      b_prev   <= 1'b0;
      step_fwd <= 1'b0;
      step_rev <= 1'b0;
    end else begin
      a_prev   <= a_now;
      b_prev   <= b_now;
      step_fwd <= next_fwd && !next_inh;
      step_rev <= next_rev && !next_inh;
    end
  end

  // Analog monitor sources
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      monitor_out_1 <= 16'h0000;
      monitor_out_2 <= 16'h0000;
    end else begin
      if (!act_sw2[`STFS_B_MON1]) begin
        monitor_out_1 <= torque_fb;
      end else if (next_loop == STFS_L_SPD) begin
        monitor_out_1 <= analog_in_1;
      end else if (next_loop == STFS_L_POS) begin
        monitor_out_1 <= pulse_speed;
      end else begin
        monitor_out_1 <= 16'h0000;
      end
      if (!act_sw2[`STFS_B_MON2]) begin
        monitor_out_2 <= motor_speed;
      end else if (next_loop == STFS_L_POS) begin
        monitor_out_2 <= pos_error;
      end else begin
        monitor_out_2 <= 16'h0000;
      end
    end
  end

  AST_TLIM: assert property (@(posedge aclk) disable iff (!aresetn)
    (next_loop == STFS_L_SPD && act_sw2[`STFS_B_TLIM] &&
     !act_sw2[`STFS_B_TFF]) |=> torque_limit_valid &&
     torque_limit_out == $past(analog_in_2))
    else $error("torque limit not routed from input 2");
  AST_TFF: assert property (@(posedge aclk) disable iff (!aresetn)
    (act_sw2[`STFS_B_TLIM] == act_sw2[`STFS_B_TFF]) |=>
     !torque_ff_valid && !torque_limit_valid)
    else $error("input 2 used while it should be ignored");
  AST_TRQ: assert property (@(posedge aclk) disable iff (!aresetn)
    next_loop == STFS_L_TRQ |=> torque_ref_valid &&
     speed_limit_valid == $past(act_sw2[`STFS_B_SPD_LIM]))
    else $error("torque loop reference roles wrong");
  AST_SIGN: assert property (@(posedge aclk) disable iff (!aresetn)
    (fmt == `STFS_FMT_SIGN && a_rise && b_now && !next_inh) |=>
     step_rev && !step_fwd)
    else $error("sign input did not set direction");
  AST_CW: assert property (@(posedge aclk) disable iff (!aresetn)
    (fmt == `STFS_FMT_CWCCW && b_rise && !next_inh) |=> step_rev)
    else $error("reverse pulse not counted");
  AST_QX1: assert property (@(posedge aclk) disable iff (!aresetn)
    (fmt == `STFS_FMT_QX1 && !a_rise) |=> !step_fwd && !step_rev)
    else $error("x1 decode counted a non rising edge");
  AST_MON1: assert property (@(posedge aclk) disable iff (!aresetn)
    (!act_sw2[`STFS_B_MON1]) |=> monitor_out_1 == $past(torque_fb))
    else $error("monitor 1 not torque");
  AST_MON2: assert property (@(posedge aclk) disable iff (!aresetn)
    (act_sw2[`STFS_B_MON2] && next_loop == STFS_L_POS) |=>
     monitor_out_2 == $past(pos_error))
    else $error("monitor 2 not position error");
  AST_PCON: assert property (@(posedge aclk) disable iff (!aresetn)
    act_method == `STFS_M_TORQUE |=> !p_control_en)
    else $error("prop input acted in torque method");
  AST_ZC: assert property (@(posedge aclk) disable iff (!aresetn)
    (act_method == `STFS_M_ZCLAMP && prop_ctrl_in) |=> zero_clamp_cmd)
    else $error("zero clamp not commanded");
  AST_INH: assert property (@(posedge aclk) disable iff (!aresetn)
    next_inh |=> !step_fwd && !step_rev && pulse_inhibit)
    else $error("pulses accepted while inhibited");
  AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (run && $past(run)) |-> $stable(act_method) && $stable(act_sw2))
    else $error("settings changed while running");
endmodule
